// *** hdl/halt_watchdog_pkg.sv ***
// Behaviour
// RULE_01: Halt with idle_select 0 enters sleep; system and time base clocks stop.
// RULE_02: Halt with idle_select 1, idle_clock_keep 0 stops only the system clock.
// RULE_03: Halt with idle_select 1, idle_clock_keep 1 keeps clocks, stops execution only.
// RULE_04: Memory, registers and ports keep their values in every halt mode.
// RULE_05: Halt clears the watchdog counter, which then counts again from zero.
// RULE_06: Halt sets powerdown_flag and clears expiry_flag.
// RULE_07: Wake on enabled Port A falling edge, interrupt or watchdog overflow.
// RULE_08: Per-pin enables pick wake pins; such a wake resumes after the halt.
// RULE_09: Overflow in power-down sets expiry_flag, wakes, resets only PC and stack pointer.
// RULE_10: powerdown_flag cleared by power-up or watchdog clear, set by halt.
// RULE_11: Disabled interrupt or full stack: resume after halt, interrupt stays pending.
// RULE_12: Enabled interrupt with free stack: normal interrupt response on wake.
// RULE_13: Interrupt already pending at halt entry cannot wake the device.
// RULE_14: Watchdog counts slow clock; timeout 2^8 to 2^18 by period select code.
// RULE_15: Watchdog control loads 0x53 on any reset, kept on power-down timeout.
// RULE_16: Watchdog enabled while key field holds 10101 or 01010.
// RULE_17: Any other key causes device reset 2 to 3 slow cycles later, sets fault flag.
// RULE_18: Key fault flag resets to 0, set only by key reset, cleared by writing 0.
// RULE_19: System control bits 6 to 3 read as 0.
// RULE_20: Only the watchdog clear and halt instructions clear the counter from software.
// RULE_21: Timeout in normal operation causes full device reset and sets expiry_flag.
// RULE_22: Wake detection and watchdog divider run from slow clock ticks.
package halt_watchdog_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_WATCHDOG_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_SYSTEM_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_CLOCK_MODE = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_PORTA_WAKE = 3'h4;

  // Reset values
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h53;
  localparam logic IDLE_SELECT_RESET = 1'b1;
  localparam logic [7:0] PORTA_WAKE_RESET = 8'h00;

  // Field positions
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 3;
  localparam int PERIOD_MSB = 2;
  localparam int PERIOD_LSB = 0;
  localparam int IDLE_CLOCK_KEEP_BIT = 7;
  localparam int KEY_FAULT_BIT = 0;
  localparam int IDLE_SELECT_BIT = 1;
  localparam int STATUS_EXPIRY_BIT = 0;
  localparam int STATUS_POWERDOWN_BIT = 1;

  // Key codes that keep the watchdog enabled
  localparam logic [4:0] KEY_ENABLE_A = 5'h15;
  localparam logic [4:0] KEY_ENABLE_B = 5'h0a;

  // Slow ticks from key corruption to reset (gives 2 to 3 slow periods)
  localparam logic [1:0] KEY_FAULT_TICKS = 2'h3;

  localparam int COUNT_WIDTH = 18;
  localparam int PORT_WIDTH = 8;
  localparam int IRQ_WIDTH = 8;

  typedef enum logic [1:0] {RUNNING, SLEEPING, IDLE_CLOCK_OFF, IDLE_CLOCK_ON} mode_type;

  // Terminal count mask for each period select code
  function automatic logic [COUNT_WIDTH-1:0] period_mask(input logic [2:0] code);
    case (code)
      3'h0: period_mask = 18'h000ff;
      3'h1: period_mask = 18'h003ff;
      3'h2: period_mask = 18'h00fff;
      3'h3: period_mask = 18'h03fff;
      3'h4: period_mask = 18'h07fff;
      3'h5: period_mask = 18'h0ffff;
      3'h6: period_mask = 18'h1ffff;
      default: period_mask = 18'h3ffff;
    endcase
  endfunction

endpackage

// *** hdl/slow_tick_gen.sv ***
`timescale 1ns/1ps
module slow_tick_gen (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow_clock,
  output logic slow_tick
);
  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic last;
    logic tick;
  } tick_state_type;

  tick_state_type state, next_state;

  assign slow_tick = state.tick;

  // Two-stage synchroniser, then rising edge to a one-cycle enable
  always_comb begin
    next_state = state;
    next_state.sync_first = slow_clock;
    next_state.sync_second = state.sync_first;
    next_state.last = state.sync_second;
    next_state.tick = state.sync_second & ~state.last;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// *** hdl/porta_wake_detect.sv ***
`timescale 1ns/1ps
module porta_wake_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow_tick,
  input wire logic [halt_watchdog_pkg::PORT_WIDTH-1:0] porta_pins,
  input wire logic [halt_watchdog_pkg::PORT_WIDTH-1:0] porta_wake_enable,
  output logic wake_fall
);
  import halt_watchdog_pkg::*;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] sync_first;
    logic [PORT_WIDTH-1:0] sync_second;
    logic [PORT_WIDTH-1:0] sampled;
    logic fall;
  } detect_state_type;

  detect_state_type state, next_state;
  logic [PORT_WIDTH-1:0] pin_fall;

  assign wake_fall = state.fall;

  // Per-pin falling edge between slow samples, gated by its enable
  genvar i;
  generate
    for (i = 0; i < PORT_WIDTH; i++) begin : g_pin
      assign pin_fall[i] = porta_wake_enable[i] & state.sampled[i] & ~state.sync_second[i]; // see RULE_08
    end
  endgenerate

  // Pins sampled only on slow ticks
  always_comb begin
    next_state = state;
    next_state.sync_first = porta_pins;
    next_state.sync_second = state.sync_first;
    next_state.fall = 1'b0;
    if (slow_tick) begin // see RULE_22
      next_state.sampled = state.sync_second;
      next_state.fall = |pin_fall;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '1;
      state.fall <= 1'b0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// *** hdl/halt_wakeup_watchdog.sv ***
`timescale 1ns/1ps
module halt_wakeup_watchdog (
  input wire logic clk,
  input wire logic reset_n,
  // Slow oscillator pin
  input wire logic slow_clock,
  // Port A pins
  input wire logic [halt_watchdog_pkg::PORT_WIDTH-1:0] porta_pins,
  // Core instruction strobes
  input wire logic halt_exec,
  input wire logic clear_watchdog_exec,
  // Core interrupt state
  input wire logic [halt_watchdog_pkg::IRQ_WIDTH-1:0] interrupt_request,
  input wire logic [halt_watchdog_pkg::IRQ_WIDTH-1:0] interrupt_enable,
  input wire logic stack_full,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Clock gating, core control and status flags
  output logic system_clock_enable,
  output logic timebase_clock_enable,
  output logic execution_hold,
  output logic wake_resume,
  output logic wake_interrupt,
  output logic pc_stack_reset,
  output logic device_reset,
  output logic powerdown_flag,
  output logic expiry_flag
);
  import halt_watchdog_pkg::*;

  typedef struct packed {
    mode_type mode;
    logic [7:0] watchdog_control;
    logic idle_clock_keep;
    logic idle_select;
    logic [PORT_WIDTH-1:0] porta_wake_enable;
    logic powerdown_flag;
    logic expiry_flag;
    logic key_fault_reset_flag;
    logic [COUNT_WIDTH-1:0] count;
    logic [1:0] key_wait;
    logic [IRQ_WIDTH-1:0] irq_armed;
    logic [7:0] rdata;
    logic system_clock_enable;
    logic timebase_clock_enable;
    logic execution_hold;
    logic wake_resume;
    logic wake_interrupt;
    logic pc_stack_reset;
    logic device_reset;
  } block_state_type;

  block_state_type state, next_state;
  logic slow_tick;
  logic porta_fall;

  // Slow clock enable
  slow_tick_gen u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .slow_clock(slow_clock),
    .slow_tick(slow_tick)
  );

  // Port A falling edge detection
  porta_wake_detect u_porta (
    .clk(clk),
    .reset_n(reset_n),
    .slow_tick(slow_tick),
    .porta_pins(porta_pins),
    .porta_wake_enable(state.porta_wake_enable),
    .wake_fall(porta_fall)
  );

  // Outputs straight from the state register
  assign reg_rdata = state.rdata;
  assign system_clock_enable = state.system_clock_enable;
  assign timebase_clock_enable = state.timebase_clock_enable;
  assign execution_hold = state.execution_hold;
  assign wake_resume = state.wake_resume;
  assign wake_interrupt = state.wake_interrupt;
  assign pc_stack_reset = state.pc_stack_reset;
  assign device_reset = state.device_reset;
  assign powerdown_flag = state.powerdown_flag;
  assign expiry_flag = state.expiry_flag;

  // Decoded watchdog and interrupt wake conditions
  logic [4:0] key;
  logic key_valid;
  logic [COUNT_WIDTH-1:0] mask;
  logic timeout;
  logic asleep;
  logic [IRQ_WIDTH-1:0] irq_wake;
  logic irq_serviced;

  always_comb begin
    key = state.watchdog_control[KEY_MSB:KEY_LSB];
    key_valid = (key == KEY_ENABLE_A) || (key == KEY_ENABLE_B); // see RULE_16
    mask = period_mask(state.watchdog_control[PERIOD_MSB:PERIOD_LSB]); // see RULE_14
    timeout = key_valid && slow_tick && ((state.count & mask) == mask); // see RULE_22
    asleep = (state.mode != RUNNING);
    irq_wake = interrupt_request & state.irq_armed; // see RULE_13
    irq_serviced = |(irq_wake & interrupt_enable) && !stack_full; // see RULE_12
  end

  // Next state: mode machine, watchdog, flags and register port
  always_comb begin
    next_state = state;
    next_state.wake_resume = 1'b0;
    next_state.wake_interrupt = 1'b0;
    next_state.pc_stack_reset = 1'b0;
    next_state.device_reset = 1'b0;
    next_state.rdata = 8'h00;

    // Watchdog divider counts slow ticks while the key is valid
    if (key_valid && slow_tick) begin
      next_state.count = state.count + 1'b1; // see RULE_14
    end

    // Register writes; only the settable fields change
    if (reg_write) begin
      case (reg_addr)
        ADDR_WATCHDOG_CONTROL: next_state.watchdog_control = reg_wdata;
        ADDR_SYSTEM_CONTROL: begin
          next_state.idle_clock_keep = reg_wdata[IDLE_CLOCK_KEEP_BIT];
          if (!reg_wdata[KEY_FAULT_BIT]) begin
            next_state.key_fault_reset_flag = 1'b0; // see RULE_18
          end
        end
        ADDR_CLOCK_MODE: next_state.idle_select = reg_wdata[IDLE_SELECT_BIT];
        ADDR_PORTA_WAKE: next_state.porta_wake_enable = reg_wdata; // see RULE_08
        default: begin
        end
      endcase
    end

    // Software clear of the watchdog
    if (clear_watchdog_exec && !asleep) begin
      next_state.count = '0; // see RULE_20
      next_state.powerdown_flag = 1'b0; // see RULE_10
    end

    // Mode machine
    case (state.mode)
      RUNNING: begin
        if (halt_exec) begin
          next_state.count = '0; // see RULE_05
          next_state.powerdown_flag = 1'b1; // see RULE_06 RULE_10
          next_state.expiry_flag = 1'b0; // see RULE_06
          next_state.irq_armed = ~interrupt_request; // see RULE_13
          if (!state.idle_select) begin
            next_state.mode = SLEEPING; // see RULE_01
          end else if (!state.idle_clock_keep) begin
            next_state.mode = IDLE_CLOCK_OFF; // see RULE_02
          end else begin
            next_state.mode = IDLE_CLOCK_ON; // see RULE_03
          end
        end else if (timeout) begin
          // Full reset on expiry in normal operation
          next_state.device_reset = 1'b1; // see RULE_21
          next_state.expiry_flag = 1'b1; // see RULE_21
          next_state.watchdog_control = WATCHDOG_CONTROL_RESET; // see RULE_15
          next_state.count = '0;
        end
      end
      SLEEPING, IDLE_CLOCK_OFF, IDLE_CLOCK_ON: begin
        // Nothing else is touched while halted
        if (timeout) begin
          next_state.mode = RUNNING; // see RULE_07 RULE_09
          next_state.expiry_flag = 1'b1; // see RULE_09
          next_state.pc_stack_reset = 1'b1; // see RULE_09
          next_state.count = '0;
        end else if (|irq_wake) begin
          next_state.mode = RUNNING; // see RULE_07
          next_state.wake_interrupt = irq_serviced; // see RULE_12
          next_state.wake_resume = !irq_serviced; // see RULE_11
        end else if (porta_fall) begin
          next_state.mode = RUNNING; // see RULE_07
          next_state.wake_resume = 1'b1; // see RULE_08
        end
      end
      default: next_state.mode = RUNNING;
    endcase

    // Corrupted key: reset after the slow tick delay
    if (key_valid) begin
      next_state.key_wait = '0;
    end else if (slow_tick) begin
      if (state.key_wait == KEY_FAULT_TICKS - 2'h1) begin
        next_state.key_wait = '0;
        next_state.device_reset = 1'b1; // see RULE_17
        next_state.key_fault_reset_flag = 1'b1; // see RULE_17 RULE_18
        next_state.watchdog_control = WATCHDOG_CONTROL_RESET; // see RULE_15
        next_state.count = '0;
        next_state.mode = RUNNING;
      end else begin
        next_state.key_wait = state.key_wait + 2'h1;
      end
    end

    // Clock gating follows the next mode
    next_state.system_clock_enable = (next_state.mode == RUNNING) || (next_state.mode == IDLE_CLOCK_ON);
    next_state.timebase_clock_enable = (next_state.mode != SLEEPING); // see RULE_01 RULE_02 RULE_03
    next_state.execution_hold = (next_state.mode != RUNNING); // see RULE_04

    // Read data in the cycle after the read strobe
    if (reg_read) begin
      case (reg_addr)
        ADDR_WATCHDOG_CONTROL: next_state.rdata = state.watchdog_control;
        ADDR_SYSTEM_CONTROL: begin
          next_state.rdata[IDLE_CLOCK_KEEP_BIT] = state.idle_clock_keep; // see RULE_19
          next_state.rdata[KEY_FAULT_BIT] = state.key_fault_reset_flag;
        end
        ADDR_CLOCK_MODE: next_state.rdata[IDLE_SELECT_BIT] = state.idle_select;
        ADDR_STATUS: begin
          next_state.rdata[STATUS_EXPIRY_BIT] = state.expiry_flag;
          next_state.rdata[STATUS_POWERDOWN_BIT] = state.powerdown_flag;
        end
        ADDR_PORTA_WAKE: next_state.rdata = state.porta_wake_enable;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.mode <= RUNNING;
      state.watchdog_control <= WATCHDOG_CONTROL_RESET; // see RULE_15
      state.idle_select <= IDLE_SELECT_RESET;
      state.porta_wake_enable <= PORTA_WAKE_RESET;
      state.system_clock_enable <= 1'b1;
      state.timebase_clock_enable <= 1'b1;
    end else begin
      state <= next_state;
    end
  end
endmodule

// *** verification/halt_wakeup_watchdog_monitor.sv ***
`timescale 1ns/1ps
// Port-level checks on halt entry, wake and watchdog outputs
module halt_wakeup_watchdog_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic halt_exec,
  input wire logic clear_watchdog_exec,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic system_clock_enable,
  input wire logic timebase_clock_enable,
  input wire logic execution_hold,
  input wire logic wake_resume,
  input wire logic wake_interrupt,
  input wire logic pc_stack_reset,
  input wire logic device_reset,
  input wire logic powerdown_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_halt_entry: assert property (halt_exec && !execution_hold |=> execution_hold && powerdown_flag)
    else $error("halt not entered");
  a_sleep_clocks: assert property (!timebase_clock_enable |-> execution_hold && !system_clock_enable)
    else $error("timebase stopped outside sleep");
  a_run_clocks: assert property (!execution_hold |-> system_clock_enable && timebase_clock_enable)
    else $error("clock stopped while running");
  a_wake_exits: assert property (wake_resume || wake_interrupt |-> !execution_hold && $past(execution_hold))
    else $error("wake pulse without halt exit");
  a_pd_cause: assert property ($rose(powerdown_flag) |-> $past(halt_exec))
    else $error("powerdown flag set without halt");
  a_clear_pd: assert property (clear_watchdog_exec && !halt_exec && !execution_hold |=> !powerdown_flag)
    else $error("powerdown flag not cleared");
  a_stall_timeout: assert property (pc_stack_reset |-> $past(execution_hold) && !device_reset)
    else $error("halted timeout misdirected");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind halt_wakeup_watchdog halt_wakeup_watchdog_monitor mon (.clk(clk), .reset_n(reset_n), .halt_exec(halt_exec),
  .clear_watchdog_exec(clear_watchdog_exec), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .system_clock_enable(system_clock_enable), .timebase_clock_enable(timebase_clock_enable),
  .execution_hold(execution_hold), .wake_resume(wake_resume), .wake_interrupt(wake_interrupt),
  .pc_stack_reset(pc_stack_reset), .device_reset(device_reset), .powerdown_flag(powerdown_flag));

// *** verification/core_model.sv ***
`timescale 1ns/1ps
// Core that issues one-cycle instruction strobes
module core_model (
  input wire logic clk,
  output logic halt_exec,
  output logic clear_watchdog_exec
);
  initial begin
    halt_exec = 1'b0;
    clear_watchdog_exec = 1'b0;
  end

  // Halt instruction strobe
  task automatic halt_op();
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
  endtask

  // Watchdog clear instruction strobe
  task automatic clear_op();
    @(posedge clk);
    clear_watchdog_exec <= 1'b1;
    @(posedge clk);
    clear_watchdog_exec <= 1'b0;
  endtask
endmodule

// *** verification/halt_wakeup_watchdog_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module halt_wakeup_watchdog_bench;
  import halt_watchdog_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slow_clock = 1'b0;
  logic [PORT_WIDTH-1:0] porta_pins = 8'hff;
  logic [IRQ_WIDTH-1:0] interrupt_request = 8'h00;
  logic [IRQ_WIDTH-1:0] interrupt_enable = 8'h00;
  logic stack_full = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, d;
  logic halt_exec, clear_watchdog_exec, system_clock_enable, timebase_clock_enable, execution_hold;
  logic wake_resume, wake_interrupt, pc_stack_reset, device_reset, powerdown_flag, expiry_flag;
  logic [3:0] evt;
  int mreg [8];
  int slow_edges = 0;
  int resets = 0;
  int err_count = 0;
  int comparisons = 0;
  int pin, n, snap, e;

  halt_wakeup_watchdog DUT (.clk(clk), .reset_n(reset_n), .slow_clock(slow_clock), .porta_pins(porta_pins),
    .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec), .interrupt_request(interrupt_request),
    .interrupt_enable(interrupt_enable), .stack_full(stack_full), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .system_clock_enable(system_clock_enable),
    .timebase_clock_enable(timebase_clock_enable), .execution_hold(execution_hold), .wake_resume(wake_resume),
    .wake_interrupt(wake_interrupt), .pc_stack_reset(pc_stack_reset), .device_reset(device_reset),
    .powerdown_flag(powerdown_flag), .expiry_flag(expiry_flag));
  core_model CORE (.clk(clk), .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec));

  assign evt = {device_reset, pc_stack_reset, wake_interrupt, wake_resume};
  // Clocks and event counters
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever #40 slow_clock = ~slow_clock;
  end
  always @(posedge slow_clock) slow_edges++;
  always @(posedge clk) if (device_reset === 1'b1) resets++;

  // Register write, mirrored into the model
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    case (a)
      3'h0: mreg[0] = v;
      3'h1: mreg[1] = (v & 8'h80) | (mreg[1] & v & 1);
      3'h2: mreg[2] = v & 8'h02;
      3'h4: mreg[4] = v;
      default: ;
    endcase
  endtask

  // Register read, data taken in the following cycle
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Bounded wait for one output event
  task automatic wait_out(input int which, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && evt[which] !== 1'b1) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= lim) begin
      err_count++;
      $display("[FAIL] event %0d exp 1 got timeout", which);
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    n = $urandom(43);
    mreg = '{8'h53, 0, 8'h02, 0, 0, 0, 0, 0};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, reserved bits, unmapped place
    reg_wr(3'h1, 8'hff);
    reg_wr(3'h5, 8'hff);
    for (int a = 0; a < 8; a++) begin
      reg_rd(a[2:0], d);
      `CHK("register", mreg[a][7:0], d)
    end
    $display("test registers done");
    // Three halt modes, Port A wake through one enabled pin
    pin = $urandom % 8;
    reg_wr(3'h4, 8'h01 << pin);
    for (int m = 0; m < 3; m++) begin
      reg_wr(3'h2, (m > 0) ? 8'h02 : 8'h00);
      reg_wr(3'h1, (m == 2) ? 8'h80 : 8'h00);
      CORE.halt_op();
      #1;
      `CHK("hold", 1'b1, execution_hold)
      `CHK("sys clock", m == 2, system_clock_enable)
      `CHK("tb clock", m > 0, timebase_clock_enable)
      `CHK("flags", 2'b10, {powerdown_flag, expiry_flag})
      @(posedge clk);
      porta_pins <= ~(8'h01 << ((pin + 1) % 8));
      repeat (40) @(posedge clk);
      #1;
      `CHK("masked pin", 1'b1, execution_hold)
      @(posedge clk);
      porta_pins <= porta_pins & ~(8'h01 << pin);
      wait_out(0, 100, n);
      `CHK("pin wake", 1'b0, execution_hold)
      @(posedge clk);
      porta_pins <= 8'hff;
      repeat (40) @(posedge clk);
    end
    $display("test halt modes done");
    // Interrupt wakes: serviced, disabled, stack full
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      interrupt_request <= 8'h01;
      interrupt_enable <= (c == 1) ? 8'h01 : 8'h03;
      stack_full <= (c == 2);
      CORE.halt_op();
      repeat (30) @(posedge clk);
      #1;
      `CHK("stale irq", 1'b1, execution_hold)
      @(posedge clk);
      interrupt_request <= 8'h03;
      wait_out((c == 0) ? 1 : 0, 20, n);
      `CHK("irq wake kind", c == 0, wake_interrupt)
      @(posedge clk);
      interrupt_request <= 8'h00;
    end
    $display("test interrupts done");
    // Watchdog timeout while halted
    reg_wr(3'h0, 8'h50);
    CORE.halt_op();
    snap = slow_edges;
    wait_out(2, 3000, n);
    `CHK("halted ticks", 1'b1, (slow_edges - snap) inside {[255:258]})
    `CHK("halted flags", 2'b11, {powerdown_flag, expiry_flag})
    reg_rd(3'h0, d);
    `CHK("watchdog_control kept", 8'h50, d)
    $display("test halted timeout done");
    // Timeout while running, after a clear, two period codes
    for (int k = 0; k < 2; k++) begin
      reg_wr(3'h0, 8'h50 | k);
      CORE.clear_op();
      snap = slow_edges;
      e = 256 << (2 * k);
      #1;
      `CHK("pd cleared", 1'b0, powerdown_flag)
      wait_out(3, 10000, n);
      `CHK("run ticks", 1'b1, (slow_edges - snap - e) inside {[-1:2]})
      `CHK("run expiry", 1'b1, expiry_flag)
      mreg[0] = 8'h53;
      reg_rd(3'h0, d);
      `CHK("watchdog_control reload", 8'h53, d)
    end
    // Every period code, even codes under key 01010, odd codes under 10101
    for (int k = 0; k < 8; k++) begin
      reg_wr(3'h0, ((k % 2) ? 8'ha8 : 8'h50) | k);
      reg_rd(3'h0, d);
      `CHK("period code", mreg[0][7:0], d)
    end
    repeat (40) @(posedge clk);
    `CHK("reset count", 2, resets)
    $display("test running timeout done");
    // Corrupted key forces reset and sets the fault flag
    snap = slow_edges;
    reg_wr(3'h0, 8'h00);
    wait_out(3, 200, n);
    `CHK("key ticks", 1'b1, (slow_edges - snap) inside {[2:4]})
    mreg[0] = 8'h53;
    mreg[1] = mreg[1] | 1;
    reg_rd(3'h1, d);
    `CHK("fault flag", mreg[1][7:0], d)
    reg_rd(3'h0, d);
    `CHK("watchdog_control key reload", 8'h53, d)
    reg_wr(3'h1, 8'h00);
    reg_rd(3'h1, d);
    `CHK("fault clear", 8'h00, d)
    $display("test key fault done");
    tally_and_finish();
  end
endmodule
